//--- sar_regs.svh
// Constants for the serial audio receiver: pin indices, lengths, ratios and timing.
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH
`define SAR_CLK_NS 8
`define SAR_STOP_NS 1500
`define SAR_STOP_CYC ((`SAR_STOP_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_DSP_MAX_LEN 8'h04
`define SAR_PACK_LEN 8'h10
`define SAR_WORD_MAX 5'h18
`define SAR_PACK_BITS 5'h10
`define SAR_FIFO_W 48
`define SAR_FIFO_DEPTH 16
`define SAR_MCLK_TOL 12'h008
`define SAR_R128 12'h080
`define SAR_R192 12'h0C0
`define SAR_R256 12'h100
`define SAR_R384 12'h180
`define SAR_R512 12'h200
`define SAR_R768 12'h300
`define SAR_DSPB_LAST 6'h1E
`define SAR_DSPA_LAST 6'h1F
`define SAR_LFSR_SEED 16'hACE1
`define SAR_PIN_MCLK 0
`define SAR_PIN_BCLK 1
`define SAR_PIN_LR 2
`define SAR_PIN_DIN 3
`define SAR_PIN_FMT 4
`endif

//--- sar_pkg.sv
// Types shared by the serial audio receiver.
package sar_pkg;
  // Framing in use; the two DSP variants differ in MSB position.
  typedef enum logic [1:0] {
    SAR_RJ = 2'b00,
    SAR_I2S = 2'b01,
    SAR_DSPA = 2'b10,
    SAR_DSPB = 2'b11
  } sar_fmt_t;
endpackage

//--- sar_fifo.sv
// Sample-pair FIFO between the serial receiver and the filter path.
`timescale 1ns/1ns
`default_nettype none
module sar_fifo #(
  parameter int W = 48, // Word width.
  parameter int DEPTH = 16 // Number of words.
) (
  input wire logic clock, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Space available.
  input wire logic [W-1:0] in_data, // Write data.
  output logic out_valid, // Data available.
  input wire logic out_ready, // Consumer takes the word.
  output logic [W-1:0] out_data // Oldest word.
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH]; // Storage.
  logic [AW:0] wr_q; // Write pointer with wrap bit.
  logic [AW:0] rd_q; // Read pointer with wrap bit.
  wire logic wr_en; // Word accepted.
  wire logic rd_en; // Word removed.

  // Full when the pointers differ only in the wrap bit.
  assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign wr_en = in_valid && in_ready;
  assign rd_en = out_valid && out_ready;

  // Storage has no reset; only the pointers define what is valid.
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers advance on each accepted transfer.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (wr_en) begin
        wr_q <= wr_q + 1'b1;
      end
      if (rd_en) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // sar_fifo
`default_nettype wire

//--- sar_rx.sv
// Serial audio receiver with clock-ratio check, stop detect and pair output.
`timescale 1ns/1ns
`default_nettype none
`include "sar_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module sar_rx (
  input wire logic clock, // System clock, 125 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic mclk_pin, // Master clock pin.
  input wire logic bclk_pin, // Bit clock pin.
  input wire logic lrclk_pin, // Frame clock pin.
  input wire logic din_pin, // Serial data pin.
  input wire logic fmt_sel_pin, // Format select pin.
  input wire logic filt_ready, // Filter path takes a pair.
  output logic [23:0] pcm_left_q, // Left sample, MSB aligned.
  output logic [23:0] pcm_right_q, // Right sample, MSB aligned.
  output logic pcm_valid_q, // One-cycle strobe per pair.
  output sar_pkg::sar_fmt_t mode_q, // Framing in use.
  output logic packed16_q, // Packed 16-bit framing seen.
  output logic mute_q, // Output muted.
  output logic pwr_down_q, // Reduced-power state.
  output logic [2:0] ratio_q, // Detected ratio code.
  output logic mclk_tick_q, // Master clock rise strobe.
  output logic dither_q, // Dither bit for the modulator.
  output logic overrun_q // Pair lost to a full FIFO.
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [4:0] pin_s1_q; // First stage, read by stage two only.
  logic [4:0] pin_s2_q; // Second stage, safe to use.
  logic [4:0] pin_s3_q; // Delayed copy for edge finding.
  wire logic [4:0] pins_w; // Raw pins grouped.

  assign pins_w = {fmt_sel_pin, din_pin, lrclk_pin, bclk_pin, mclk_pin};

  // Every pin passes two flops before use.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      pin_s3_q <= 5'h00;
    end else begin
      pin_s1_q <= pins_w;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  wire logic b_rise; // Bit clock rising edge.
  wire logic m_rise; // Master clock rising edge.
  wire logic lr_rise; // Frame clock rise, free of bit clock.
  wire logic lr; // Synchronised frame clock.
  wire logic din; // Synchronised data.
  wire logic fsel; // Synchronised format select.

  assign b_rise = pin_s2_q[`SAR_PIN_BCLK] && !pin_s3_q[`SAR_PIN_BCLK];
  assign m_rise = pin_s2_q[`SAR_PIN_MCLK] && !pin_s3_q[`SAR_PIN_MCLK];
  assign lr_rise = pin_s2_q[`SAR_PIN_LR] && !pin_s3_q[`SAR_PIN_LR];
  assign lr = pin_s2_q[`SAR_PIN_LR];
  assign din = pin_s2_q[`SAR_PIN_DIN];
  assign fsel = pin_s2_q[`SAR_PIN_FMT];

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Left-align an n-bit word in 24 bits, zero below.
  function automatic logic [23:0] sar_align(input logic [23:0] w,
                                            input logic [4:0] n);
    sar_align = (n == 5'h00) ? 24'h000000 : (w << (`SAR_WORD_MAX - n));
  endfunction

  // True when count c lies within tolerance of ratio r.
  function automatic logic sar_near(input logic [11:0] c,
                                    input logic [11:0] r);
    sar_near = (c + `SAR_MCLK_TOL >= r) && (c <= r + `SAR_MCLK_TOL);
  endfunction

  // Ratio code with a match flag on top.
  function automatic logic [3:0] sar_ratio(input logic [11:0] c);
    if (sar_near(c, `SAR_R128)) sar_ratio = 4'h8;
    else if (sar_near(c, `SAR_R192)) sar_ratio = 4'h9;
    else if (sar_near(c, `SAR_R256)) sar_ratio = 4'hA;
    else if (sar_near(c, `SAR_R384)) sar_ratio = 4'hB;
    else if (sar_near(c, `SAR_R512)) sar_ratio = 4'hC;
    else if (sar_near(c, `SAR_R768)) sar_ratio = 4'hD;
    else sar_ratio = 4'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame clock tracking at bit clock rises.
  logic lr_b_q; // Frame clock at the last bit clock rise.
  logic [7:0] cnt_q; // Rises since the last frame transition.
  logic [5:0] dcnt_q; // Rises since the last frame rise.
  logic dsp_q; // Short sync pulse framing.
  logic len16_q; // Previous half was exactly 16 clocks.
  wire logic tr; // Frame clock changed at this rise.
  wire logic fall_tr; // Falling transition.

  assign tr = b_rise && (lr != lr_b_q);
  assign fall_tr = tr && !lr;

  // Counters saturate so a stalled link cannot wrap them.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lr_b_q <= 1'b0;
      cnt_q <= 8'h00;
      dcnt_q <= 6'h00;
    end else if (b_rise) begin
      lr_b_q <= lr;
      cnt_q <= tr ? 8'h00 : (cnt_q == 8'hFF ? cnt_q : cnt_q + 8'h01);
      dcnt_q <= (tr && lr) ? 6'h00 : (&dcnt_q ? dcnt_q : dcnt_q + 6'h01);
    end
  end

  // The high length is known at the fall; short means DSP.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dsp_q <= 1'b0;
      len16_q <= 1'b0;
      packed16_q <= 1'b0;
    end else begin
      if (fall_tr) begin
        dsp_q <= (cnt_q + 8'h01) <= `SAR_DSP_MAX_LEN;
      end
      if (tr) begin
        len16_q <= (cnt_q + 8'h01) == `SAR_PACK_LEN;
        packed16_q <= len16_q && ((cnt_q + 8'h01) == `SAR_PACK_LEN);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Format selection.
  sar_pkg::sar_fmt_t mode_w; // Framing in use now.

  assign mode_w = dsp_q ? (fsel ? sar_pkg::SAR_DSPA : sar_pkg::SAR_DSPB)
                        : (fsel ? sar_pkg::SAR_I2S : sar_pkg::SAR_RJ);

  ////////////////////////////////////////////////////////////////////////////
  // Shift registers, all MSB first.
  logic [23:0] i2s_sr_q; // I2S word being built.
  logic [4:0] i2s_n_q; // Bits held in it.
  logic [15:0] rj_sr_q; // Last 16 bits seen.
  logic [31:0] dsp_sr_q; // Last 32 bits seen.
  wire logic [4:0] max_w; // Bit limit for I2S.
  wire logic room_w; // I2S word still takes bits.
  wire logic [23:0] i2s_fin_w; // I2S word at the transition.
  wire logic [4:0] i2s_fn_w; // Its bit count.

  assign max_w = packed16_q ? `SAR_PACK_BITS : `SAR_WORD_MAX;
  assign room_w = i2s_n_q < max_w;
  // The I2S LSB lands on the rise that sees the transition.
  assign i2s_fin_w = room_w ? {i2s_sr_q[22:0], din} : i2s_sr_q;
  assign i2s_fn_w = room_w ? i2s_n_q + 5'h01 : i2s_n_q;

  // I2S restarts at each transition, so the MSB is the next rise.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      i2s_sr_q <= 24'h000000;
      i2s_n_q <= 5'h00;
    end else if (tr) begin
      i2s_sr_q <= 24'h000000;
      i2s_n_q <= 5'h00;
    end else if (b_rise && room_w) begin
      i2s_sr_q <= {i2s_sr_q[22:0], din};
      i2s_n_q <= i2s_n_q + 5'h01;
    end
  end

  // Right-justified and DSP words are read from free-running shifters.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rj_sr_q <= 16'h0000;
      dsp_sr_q <= 32'h00000000;
    end else if (b_rise) begin
      rj_sr_q <= {rj_sr_q[14:0], din};
      dsp_sr_q <= {dsp_sr_q[30:0], din};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word completion and pairing.
  wire logic is_left_w; // Half just ended carried left.
  wire logic [23:0] word_w; // Finished word of that half.
  wire logic dsp_done_w; // Last DSP bit arrives now.
  wire logic [31:0] dsp_w; // Both DSP words.
  wire logic push_w; // Pair complete.
  wire logic [23:0] pair_l_w; // Left of the pair.
  wire logic [23:0] pair_r_w; // Right of the pair.
  wire logic in_ready; // FIFO has space.
  logic [23:0] left_q; // Left word waiting for its right.

  assign is_left_w = (mode_w == sar_pkg::SAR_I2S) ? !lr_b_q
                                                  : lr_b_q;
  // Right-justified: the word ends on the rise before the transition.
  assign word_w = (mode_w == sar_pkg::SAR_I2S) ? sar_align(i2s_fin_w, i2s_fn_w)
                                               : {rj_sr_q, 8'h00};
  assign dsp_w = {dsp_sr_q[30:0], din};
  assign dsp_done_w = dsp_q && b_rise && !tr &&
                      (dcnt_q == (fsel ? `SAR_DSPA_LAST : `SAR_DSPB_LAST));
  assign push_w = dsp_q ? dsp_done_w : (tr && !is_left_w);
  assign pair_l_w = dsp_q ? {dsp_w[31:16], 8'h00} : left_q;
  assign pair_r_w = dsp_q ? {dsp_w[15:0], 8'h00} : word_w;

  // Hold the left word until its partner ends.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      left_q <= 24'h000000;
    end else if (tr && is_left_w && !dsp_q) begin
      left_q <= word_w;
    end
  end

  // The link cannot be stalled, so a full FIFO loses the pair.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      overrun_q <= 1'b0;
    end else if (push_w && !in_ready) begin
      overrun_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pair buffer toward the filter path.
  wire logic f_valid; // FIFO holds a pair.
  wire logic [47:0] f_data; // Oldest pair.

  sar_fifo #(
    .W(`SAR_FIFO_W),
    .DEPTH(`SAR_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(push_w),
    .in_ready(in_ready),
    .in_data({pair_l_w, pair_r_w}),
    .out_valid(f_valid),
    .out_ready(filt_ready),
    .out_data(f_data)
  );

  // Muted pairs are still strobed, as silence.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pcm_left_q <= 24'h000000;
      pcm_right_q <= 24'h000000;
      pcm_valid_q <= 1'b0;
      mode_q <= sar_pkg::SAR_RJ;
    end else begin
      pcm_valid_q <= f_valid && filt_ready;
      pcm_left_q <= mute_q ? 24'h000000 : f_data[47:24];
      pcm_right_q <= mute_q ? 24'h000000 : f_data[23:0];
      mode_q <= mode_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clock supervision.
  logic [11:0] mcnt_q; // Master clocks in this frame.
  logic [7:0] idle_q; // Cycles since the last master clock rise.
  logic [15:0] lfsr_q; // Dither source.
  wire logic [3:0] rat_w; // Match flag and code.
  wire logic [7:0] idle_d; // Next idle count.

  assign rat_w = sar_ratio(mcnt_q);
  assign idle_d = m_rise ? 8'h00 :
                  (idle_q == 8'(`SAR_STOP_CYC) ? idle_q : idle_q + 8'h01);

  // Count per frame; a faster master clock than we can sample looks wrong.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mcnt_q <= 12'h000;
      ratio_q <= 3'h0;
      mute_q <= 1'b1;
    end else begin
      if (lr_rise) begin
        mcnt_q <= {11'h000, m_rise};
        ratio_q <= rat_w[2:0];
      end else if (m_rise && !(&mcnt_q)) begin
        mcnt_q <= mcnt_q + 12'h001;
      end
      if (pwr_down_q) begin
        mute_q <= 1'b1;
      end else if (lr_rise) begin
        mute_q <= !rat_w[3];
      end
    end
  end

  // Power down after the master clock has been quiet long enough.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      idle_q <= 8'(`SAR_STOP_CYC);
      pwr_down_q <= 1'b1;
      mclk_tick_q <= 1'b0;
    end else begin
      idle_q <= idle_d;
      pwr_down_q <= idle_d == 8'(`SAR_STOP_CYC);
      mclk_tick_q <= m_rise;
    end
  end

  // Dither steps with the master clock so it tracks the sample rate.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lfsr_q <= `SAR_LFSR_SEED;
      dither_q <= 1'b0;
    end else if (m_rise) begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      dither_q <= lfsr_q[0] && !mute_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_bad_frame;
    lr_rise && !rat_w[3];
  endsequence

  sequence s_quiet;
    m_rise ##1 !m_rise [*8];
  endsequence

  mute_ratio_a: assert property (s_bad_frame |=> mute_q)
    else $error("Mute not raised on a bad clock ratio.");
  pdn_enter_a: assert property (idle_q == 8'(`SAR_STOP_CYC - 1) && !m_rise
                                |=> pwr_down_q)
    else $error("Power down late after master clock stop.");
  pdn_hold_a: assert property (s_quiet |-> !pwr_down_q)
    else $error("Power down entered too early.");
  dsp_detect_a: assert property (fall_tr && cnt_q < 8'h04 |=> dsp_q)
    else $error("Short sync pulse not taken as DSP.");
  dsp_long_a: assert property (fall_tr && cnt_q > 8'h03 |=> !dsp_q)
    else $error("Long frame pulse taken as DSP.");
  fmt_sel_a: assert property (!dsp_q |-> mode_w == (fsel ? sar_pkg::SAR_I2S
                                                       : sar_pkg::SAR_RJ))
    else $error("Format select not honoured.");
  dsp_var_a: assert property (dsp_q |-> mode_w == (fsel ? sar_pkg::SAR_DSPA
                                                      : sar_pkg::SAR_DSPB))
    else $error("DSP variant wrong.");
  rj_pad_a: assert property (push_w && mode_w == sar_pkg::SAR_RJ
                             |-> pair_r_w[7:0] == 8'h00)
    else $error("Right-justified word not 16 bits.");
  pack16_a: assert property (push_w && packed16_q && mode_w == sar_pkg::SAR_I2S
                             |-> pair_r_w[7:0] == 8'h00)
    else $error("Packed word wider than 16 bits.");
  valid_pop_a: assert property (pcm_valid_q |-> $past(f_valid && filt_ready))
    else $error("Pair strobe without a FIFO pop.");
  mute_zero_a: assert property (pcm_valid_q && $past(mute_q)
                                |-> pcm_left_q == 24'h000000)
    else $error("Muted pair not silent.");
endmodule // sar_rx
`default_nettype wire

//--- sar_src.sv
// Behavioural audio source: master clock, bit clock, frame clock and serial data.
`timescale 1ns/1ns
`default_nettype none
module sar_src (
  input wire logic run, // Send frames back to back.
  input wire logic [1:0] fmt, // 0 right-justified, 1 I2S, 2 DSP B, 3 DSP A.
  input wire logic [5:0] half, // Bit clocks per half frame.
  input wire logic [5:0] wlen, // Word length in bits.
  input wire logic [31:0] left, // Left word, MSB aligned.
  input wire logic [31:0] right, // Right word, MSB aligned.
  input wire logic [5:0] mhp, // Master clock half period in ns; zero stops it.
  output logic mclk, // Master clock.
  output logic bclk, // Bit clock.
  output logic lrclk, // Frame clock.
  output logic din // Serial data.
);
  logic [1:0] f_q; // Format taken at frame start.
  logic [5:0] h_q; // Half length taken at frame start.
  logic [5:0] w_q; // Word length taken at frame start.
  logic [5:0] hp_q = 6'h00; // Master clock half period in use.
  logic [31:0] l_q; // Left word of this frame.
  logic [31:0] r_q; // Right word of this frame.
  logic [31:0] prev_q = 32'h00000000; // Right word before; its I2S tail lands in this frame.

  // One bit clock period: data and frame clock change while the bit clock is low.
  task automatic send_bit(input int r);
    int k;
    int j;
    logic [31:0] w;
    k = r % h_q;
    w = (r < h_q) ? l_q : r_q;
    case (f_q)
      2'h0: begin
        lrclk = (r < h_q); // High frame clock carries the left word.
        j = k - (h_q - 16); // LSB on the last rise before the change.
      end
      2'h1: begin
        lrclk = (r >= h_q); // Low frame clock carries the left word.
        j = k - 1; // MSB on the second rise after the change.
        if (k == 0) begin
          w = (r < h_q) ? prev_q : l_q;
          j = h_q - 1;
        end
      end
      default: begin
        lrclk = (r == 0); // Sync pulse of one bit clock.
        j = r - f_q[0]; // Variant A starts one rise later.
        w = {l_q[31:16], r_q[31:16]}; // Left then right, 16 bits each.
      end
    endcase
    din = (j >= 0 && j < w_q) ? w[31 - j] : 1'b0; // MSB first, unused bits zero.
    #62;
    bclk = 1'b1;
    #63;
    bclk = 1'b0;
  endtask

  // Master clock runs free; the X guard avoids a stuck unknown at time zero.
  always begin
    if (hp_q == 6'h00) begin
      mclk = 1'b0;
      #8;
    end else begin
      #(hp_q);
      mclk = (mclk === 1'b1) ? 1'b0 : 1'b1; // Ratio to the frame is kept by the caller.
    end
  end

  // Settings are taken only at a frame start, so a change never splits a word.
  // Between bursts the bit clock stands still and the data line toggles.
  always begin
    hp_q = mhp;
    if (run !== 1'b1) begin
      bclk = 1'b0;
      lrclk = 1'b0;
      din = (din === 1'b1) ? 1'b0 : 1'b1;
      #8;
    end else begin
      f_q = fmt;
      h_q = half;
      w_q = wlen;
      l_q = left;
      r_q = right;
      for (int r = 0; r < 2 * h_q; r++) begin
        send_bit(r);
      end
      prev_q = r_q;
    end
  end
endmodule // sar_src
`default_nettype wire

//--- sar_rx_test.sv
// Self-checking bench for the serial audio receiver driven by a behavioural source.
`timescale 1ns/1ns
`default_nettype none
`define SAR_CHECK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end

////////////////////////////////////////////////////////////////////////////////
module sar_rx_test;
  typedef struct packed {
    logic [1:0] fmt; // Source format code.
    logic [5:0] half; // Bit clocks per half frame.
    logic [5:0] wlen; // Word length sent.
    logic [31:0] l; // Left word, MSB aligned.
    logic [31:0] r; // Right word, MSB aligned.
    logic [5:0] mhp; // Master clock half period.
    logic mu; // Mute expected.
    logic [2:0] ratio; // Ratio code expected.
  } sar_row_t;

  logic clock = 1'b0; // System clock, 8 ns.
  logic sys_rst = 1'b1; // Synchronous reset.
  logic fmt_sel_pin = 1'b0; // Format select pin.
  logic filt_ready = 1'b0; // Filter side takes pairs.
  logic run = 1'b0; // Source sends frames.
  logic [1:0] fmt = 2'h1; // Source format.
  logic [5:0] half = 6'h20; // Source half length.
  logic [5:0] wlen = 6'h18; // Source word length.
  logic [31:0] left = 32'h00000000; // Source left word.
  logic [31:0] right = 32'h00000000; // Source right word.
  logic [5:0] mhp = 6'h00; // Master clock stopped at start.
  wire logic mclk_pin; // Master clock wire.
  wire logic bclk_pin; // Bit clock wire.
  wire logic lrclk_pin; // Frame clock wire.
  wire logic din_pin; // Data wire.
  logic [23:0] pcm_left_q; // Left sample out.
  logic [23:0] pcm_right_q; // Right sample out.
  logic pcm_valid_q; // Pair strobe.
  sar_pkg::sar_fmt_t mode_q; // Framing in use.
  logic packed16_q; // Packed framing seen.
  logic mute_q; // Muted.
  logic pwr_down_q; // Power down.
  logic [2:0] ratio_q; // Ratio code.
  logic overrun_q; // Pair lost.
  logic mclk_tick_q; // Master clock rise strobe.
  logic dither_q; // Dither bit.
  int ticks = 0; // Master clock strobes seen.
  logic [23:0] got_l; // Last left popped.
  logic [23:0] got_r; // Last right popped.
  logic [1:0] exp_m; // Expected framing code.
  logic [7:0] cnt; // Strobes counted.
  int errors = 0; // Mismatches.
  int n_tests = 0; // Comparisons.
  sar_row_t rows [9]; // Ordinary cases.

  sar_src sar_src_inst (.run(run), .fmt(fmt), .half(half), .wlen(wlen), .left(left),
    .right(right), .mhp(mhp), .mclk(mclk_pin), .bclk(bclk_pin), .lrclk(lrclk_pin),
    .din(din_pin));

  sar_rx sar_rx_inst (.clock(clock), .sys_rst(sys_rst), .mclk_pin(mclk_pin),
    .bclk_pin(bclk_pin), .lrclk_pin(lrclk_pin), .din_pin(din_pin), .fmt_sel_pin(fmt_sel_pin),
    .filt_ready(filt_ready), .pcm_left_q(pcm_left_q), .pcm_right_q(pcm_right_q),
    .pcm_valid_q(pcm_valid_q), .mode_q(mode_q), .packed16_q(packed16_q), .mute_q(mute_q),
    .pwr_down_q(pwr_down_q), .ratio_q(ratio_q), .mclk_tick_q(mclk_tick_q), .dither_q(dither_q),
    .overrun_q(overrun_q));

  // Free-running system clock.
  always begin
    #4 clock = ~clock;
  end

  // Counts master clock strobes so the tick output is watched at all.
  always @(posedge clock) begin
    if (mclk_tick_q === 1'b1) begin
      ticks <= ticks + 1;
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Waits for n pair strobes, keeping the last pair; a missing strobe counts as a mismatch.
  task automatic wait_pairs(input int n);
    int c;
    c = 0;
    while (n > 0 && c < 4000) begin
      @(posedge clock);
      #1;
      c++;
      if (pcm_valid_q === 1'b1) begin
        n--;
        c = 0;
        got_l = pcm_left_q;
        got_r = pcm_right_q;
      end
    end
    if (n > 0) begin
      errors++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, the table of cases, then FIFO fill and master clock stop.
  initial begin
    rows[0] = '{2'h1, 6'h20, 6'h18, 32'hA5C3F100, 32'h5A3C0F00, 6'h1F, 1'b0, 3'h0};
    rows[1] = '{2'h1, 6'h20, 6'h10, 32'h80010000, 32'h7FFE0000, 6'h1F, 1'b0, 3'h0};
    rows[2] = '{2'h1, 6'h20, 6'h1C, 32'h12345678, 32'hFEDCBA98, 6'h15, 1'b0, 3'h1};
    rows[3] = '{2'h1, 6'h18, 6'h18, 32'hC0FFEE00, 32'h0BADF000, 6'h17, 1'b0, 3'h0};
    rows[4] = '{2'h0, 6'h20, 6'h10, 32'hBEEF0000, 32'h12340000, 6'h1F, 1'b0, 3'h0};
    rows[5] = '{2'h0, 6'h18, 6'h10, 32'hF00D0000, 32'h00FF0000, 6'h17, 1'b0, 3'h0};
    rows[6] = '{2'h1, 6'h10, 6'h10, 32'h11110000, 32'h22220000, 6'h1F, 1'b1, 3'h0};
    rows[7] = '{2'h2, 6'h20, 6'h20, 32'hABCD0000, 32'h13570000, 6'h1F, 1'b0, 3'h0};
    rows[8] = '{2'h3, 6'h20, 6'h20, 32'h24680000, 32'h9BDF0000, 6'h1F, 1'b0, 3'h0};
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    `SAR_CHECK({pcm_valid_q, mute_q, pwr_down_q, overrun_q, packed16_q}, 5'h0C)
    `SAR_CHECK({mode_q, ratio_q}, 5'h00)
    @(posedge clock);
    mhp <= 6'h1F;
    repeat (30) @(posedge clock);
    #1;
    `SAR_CHECK(pwr_down_q, 1'b0)
    `SAR_CHECK(ticks != 0, 1'b1)
    `SAR_CHECK(dither_q, 1'b0)
    filt_ready <= 1'b1;
    run <= 1'b1;
    // Each row is given five pairs to settle through mode, ratio and mute changes.
    for (int i = 0; i < 9; i++) begin
      @(posedge clock);
      fmt <= rows[i].fmt;
      fmt_sel_pin <= rows[i].fmt[0];
      half <= rows[i].half;
      wlen <= rows[i].wlen;
      left <= rows[i].l;
      right <= rows[i].r;
      mhp <= rows[i].mhp;
      exp_m = rows[i].fmt[1] ? {1'b1, ~rows[i].fmt[0]} : rows[i].fmt;
      wait_pairs(5);
      `SAR_CHECK(got_l, rows[i].mu ? 24'h000000 : rows[i].l[31:8])
      `SAR_CHECK(got_r, rows[i].mu ? 24'h000000 : rows[i].r[31:8])
      `SAR_CHECK(mode_q, exp_m)
      `SAR_CHECK(packed16_q, rows[i].half == 6'h10)
      `SAR_CHECK(mute_q, rows[i].mu)
      `SAR_CHECK(ratio_q, rows[i].ratio)
    end
    // Fill the FIFO with the filter side stalled, then stop the source and drain.
    @(posedge clock);
    filt_ready <= 1'b0;
    repeat (18500) @(posedge clock);
    run <= 1'b0;
    repeat (1500) @(posedge clock);
    #1;
    `SAR_CHECK({overrun_q, pcm_valid_q}, 2'h2)
    @(posedge clock);
    filt_ready <= 1'b1;
    cnt = 8'h00;
    repeat (40) begin
      @(posedge clock);
      #1;
      if (pcm_valid_q === 1'b1) begin
        cnt++;
        got_l = pcm_left_q;
      end
    end
    `SAR_CHECK(cnt, 8'h10)
    `SAR_CHECK(got_l, 24'h246800)
    // Stop the master clock: power down must not come early and must come within 215 cycles.
    @(posedge clock);
    mhp <= 6'h00;
    repeat (150) @(posedge clock);
    #1;
    `SAR_CHECK(pwr_down_q, 1'b0)
    repeat (65) @(posedge clock);
    #1;
    `SAR_CHECK(pwr_down_q, 1'b1)
    conclude();
  end

  // Watchdog beyond the expected run of about 60,000 cycles, kept under 100,000.
  initial begin
    #(95000 * 8);
    errors++;
    conclude();
  end
endmodule // sar_rx_test
`default_nettype wire
